// ===== design/slave_serial_config_load.sv
// Purpose: Slave serial configuration logic: clear, initialise, load, start up.
// Assumes: The program, bit clock, data, clear-done and mode pins are asynchronous to i_sys_clk and pass two flip-flops.
// Notes: The bit clock must stay well below half the system clock rate.
//
// Summary of operation
// R1: Master waits 55 to 275 us after clear-done.
// R2: Capture serial bit on bit clock rising edge.
// R3: Pass-through output changes on bit clock falling edge.
// R4: After own share, forward remaining bits downstream.
// R5: Internal oscillator only runs during initialization.
// R6: Four start-up cycles, each on a rising edge.
// R7: Done in one, I/Os two, reset release three.
// R8: Configuration ends and user mode starts in four.
// R9: Master clocks all four start-up cycles.
// R10: Start-up needs count match and memory full.
// R11: Hold 24-bit header length count in register.
// R12: Count rising edges from clear-done, compare length.
// R13: Master gives length count plus four cycles.
// R14: Missing done means error; done is reported.
// R15: High-during-config stays high until I/Os active.
// R16: Low-during-config stays low until I/Os active.
// R17: Master keeps bit clock at most 10 MHz.
// R18: Master may pause, resumes until done seen.
// R19: Master may use clear-done as interrupt request.
// R20: Repeat clear passes while program low, one more.
// R21: Master holds program low at most 500 us.
// R22: Sample mode pin after clear-done rises.
// R23: Clear-done held low externally delays configuration.
// R24: Master changes serial input only while clock low.
`timescale 1ns/1ps
`include "slave_serial_config_load_map.svh"
module slave_serial_config_load
  import slave_serial_config_load_pkg::*;
#(
  parameter int WORD_WIDTH = 8,
  parameter int MEM_DEPTH = 16,
  parameter int INIT_OSC_CYCLES = `SSC_INIT_OSC_CYC
) (
  input wire logic i_sys_clk, // System clock, 25 MHz.
  input wire logic i_nrst, // Asynchronous reset, active low.
  input wire logic i_program_n, // Program pin, low starts clearing.
  input wire logic i_config_bit_clock, // Bit clock driven by the master.
  input wire logic i_din, // Serial configuration data in.
  input wire logic i_mode, // Mode pin, high selects slave serial.
  input wire logic i_init_line, // Level of the open-drain clear-done line.
  input wire logic i_user_hdc, // User function of the high-during-config pin.
  input wire logic i_user_ldc_n, // User function of the low-during-config pin.
  input wire logic [$clog2(MEM_DEPTH)-1:0] i_cfg_raddr, // Memory read address.
  output logic o_dout, // Pass-through serial data out.
  output logic o_init_out, // Clear-done line output value.
  output logic o_init_oe, // Clear-done line driven while high.
  output logic o_done_out, // Done line output value.
  output logic o_done_oe, // Done line driven while high.
  output logic o_high_during_config, // High during configuration.
  output logic o_low_during_config_n, // Low during configuration.
  output logic o_global_set_reset_net, // Global set/reset held while high.
  output logic o_user_mode, // User operation has begun.
  output logic o_osc_active, // Internal oscillator running.
  output logic [WORD_WIDTH-1:0] o_cfg_rdata // Configuration memory word.
);

  localparam int AW = $clog2(MEM_DEPTH);
  localparam int OSC_W = $clog2(INIT_OSC_CYCLES + 1);
  localparam int WCW = $clog2(WORD_WIDTH + 1);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  generate
    if (MEM_DEPTH < 2 || WORD_WIDTH < 2 || INIT_OSC_CYCLES < 1) begin : g_bad
      $error("slave_serial_config_load: unsupported parameter values");
    end
  endgenerate

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [`SSC_PIN_COUNT-1:0] pins_raw;
  logic [`SSC_PIN_COUNT-1:0] pins_m_q;
  logic [`SSC_PIN_COUNT-1:0] pins_s_q;
  logic clk_prev_q;

  assign pins_raw[`SSC_PIN_PROG] = i_program_n;
  assign pins_raw[`SSC_PIN_CLK] = i_config_bit_clock;
  assign pins_raw[`SSC_PIN_DIN] = i_din;
  assign pins_raw[`SSC_PIN_INIT] = i_init_line;
  assign pins_raw[`SSC_PIN_MODE] = i_mode;

  genvar gi;
  generate
    for (gi = 0; gi < `SSC_PIN_COUNT; gi++) begin : g_sync
      always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          pins_m_q[gi] <= 1'(`SSC_PIN_RESET >> gi);
          pins_s_q[gi] <= 1'(`SSC_PIN_RESET >> gi);
        end else begin
          pins_m_q[gi] <= pins_raw[gi];
          pins_s_q[gi] <= pins_m_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_prev_q <= 1'(`SSC_PIN_RESET >> `SSC_PIN_CLK);
    end else begin
      clk_prev_q <= pins_s_q[`SSC_PIN_CLK];
    end
  end

  wire program_n_s = pins_s_q[`SSC_PIN_PROG];
  wire din_s = pins_s_q[`SSC_PIN_DIN];
  wire init_line_s = pins_s_q[`SSC_PIN_INIT];
  wire mode_s = pins_s_q[`SSC_PIN_MODE];
  wire clk_rise = pins_s_q[`SSC_PIN_CLK] & ~clk_prev_q;
  wire clk_fall = ~pins_s_q[`SSC_PIN_CLK] & clk_prev_q;

  // ****************************************************************
  // State and datapath registers
  // ****************************************************************
  cfg_state_t state_q, state_d;
  logic last_pass_q, last_pass_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [OSC_W-1:0] osc_q, osc_d;
  logic [`SSC_LEN_BITS-1:0] len_q, len_d;
  logic [`SSC_LEN_BITS-1:0] bit_cnt_q, bit_cnt_d;
  logic [`SSC_LEN_BITS-1:0] hdr_cnt_q, hdr_cnt_d;
  logic [WORD_WIDTH-1:0] word_q, word_d;
  logic [WCW-1:0] word_cnt_q, word_cnt_d;
  logic mem_full_q, mem_full_d;
  logic last_bit_q, last_bit_d;
  logic dout_q, dout_d;
  logic hdc_q, ldc_n_q;

  function automatic logic is_loading(input cfg_state_t s);
    return s inside {st_load, st_wait_cycle_one, st_startup_cycle_one,
                     st_startup_cycle_two, st_startup_cycle_three};
  endfunction

  wire in_clear = (state_q == st_clear);
  wire pass_end = (addr_q == AW'(MEM_DEPTH - 1));
  wire hdr_done = (hdr_cnt_q == `SSC_LEN_BITS'(`SSC_LEN_BITS));
  wire start_ok = hdr_done && (bit_cnt_q == len_q) && mem_full_q; // [R10]
  wire take_bit = clk_rise && (state_q == st_load);
  wire data_bit = take_bit && hdr_done && !mem_full_q;
  wire word_end = data_bit && (word_cnt_q == WCW'(WORD_WIDTH - 1));
  wire [WORD_WIDTH-1:0] word_next = {word_q[WORD_WIDTH-2:0], din_s};

  wire io_active = state_q inside {st_startup_cycle_two, st_startup_cycle_three, st_user};
  wire done_high = io_active || (state_q == st_startup_cycle_one); // [R7]

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    last_pass_d = last_pass_q;
    addr_d = addr_q;
    osc_d = osc_q;
    case (state_q)
      st_clear: begin
        addr_d = addr_q + AW'(1);
        if (pass_end) begin
          addr_d = '0;
          if (last_pass_q) begin // [R20]
            state_d = st_init_hold;
          end else begin
            last_pass_d = program_n_s; // [R20]
          end
        end
      end
      st_init_hold: begin
        if (init_line_s) begin // [R23]
          state_d = st_init;
          osc_d = '0;
        end
      end
      st_init: begin
        osc_d = osc_q + OSC_W'(1); // [R5]
        if (osc_q == OSC_W'(INIT_OSC_CYCLES - 1)) begin
          state_d = mode_s ? st_load : st_no_mode; // [R22]
        end
      end
      st_no_mode: begin
        state_d = st_no_mode;
      end
      st_load: begin
        if (start_ok) begin
          state_d = st_wait_cycle_one;
        end
        if (word_end) begin
          addr_d = addr_q + AW'(1);
        end
      end
      st_wait_cycle_one: begin
        if (clk_rise) begin
          state_d = st_startup_cycle_one; // [R6]
        end
      end
      st_startup_cycle_one: begin
        if (clk_rise) begin
          state_d = st_startup_cycle_two; // [R6]
        end
      end
      st_startup_cycle_two: begin
        if (clk_rise) begin
          state_d = st_startup_cycle_three; // [R6]
        end
      end
      st_startup_cycle_three: begin
        if (clk_rise) begin
          state_d = st_user; // [R8]
        end
      end
      st_user: begin
        state_d = st_user;
      end
      default: begin
        state_d = st_clear;
      end
    endcase
    if (!program_n_s) begin // [R20]
      state_d = st_clear;
      last_pass_d = 1'b0;
      if (!in_clear) begin
        addr_d = '0;
      end
    end
  end

  // ****************************************************************
  // Bit capture, length count and pass-through
  // ****************************************************************
  always_comb begin
    len_d = len_q;
    bit_cnt_d = bit_cnt_q;
    hdr_cnt_d = hdr_cnt_q;
    word_d = word_q;
    word_cnt_d = word_cnt_q;
    mem_full_d = mem_full_q;
    last_bit_d = last_bit_q;
    dout_d = dout_q;
    if (in_clear || state_q == st_init_hold || state_q == st_init) begin
      len_d = `SSC_LEN_RESET;
      bit_cnt_d = '0;
      hdr_cnt_d = '0;
      word_cnt_d = '0;
      mem_full_d = 1'b0;
      last_bit_d = 1'b1;
      dout_d = 1'b1;
    end
    if (take_bit) begin
      last_bit_d = mem_full_q ? din_s : last_bit_q; // [R2] [R4]
      bit_cnt_d = bit_cnt_q + `SSC_LEN_BITS'(1); // [R12]
      if (!hdr_done) begin
        len_d = {len_q[`SSC_LEN_BITS-2:0], din_s}; // [R11]
        hdr_cnt_d = hdr_cnt_q + `SSC_LEN_BITS'(1);
      end
    end
    if (data_bit) begin
      word_d = word_next; // [R2]
      word_cnt_d = word_end ? '0 : word_cnt_q + WCW'(1);
      if (word_end && pass_end) begin
        mem_full_d = 1'b1;
      end
    end
    if (clk_fall && mem_full_q && is_loading(state_q)) begin
      dout_d = last_bit_q; // [R3] [R4]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= st_clear;
      last_pass_q <= 1'b0;
      addr_q <= '0;
      osc_q <= '0;
    end else begin
      state_q <= state_d;
      last_pass_q <= last_pass_d;
      addr_q <= addr_d;
      osc_q <= osc_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      len_q <= `SSC_LEN_RESET;
      bit_cnt_q <= '0;
      hdr_cnt_q <= '0;
      word_q <= '0;
      word_cnt_q <= '0;
      mem_full_q <= 1'b0;
      last_bit_q <= 1'b1;
      dout_q <= 1'b1;
    end else begin
      len_q <= len_d;
      bit_cnt_q <= bit_cnt_d;
      hdr_cnt_q <= hdr_cnt_d;
      word_q <= word_d;
      word_cnt_q <= word_cnt_d;
      mem_full_q <= mem_full_d;
      last_bit_q <= last_bit_d;
      dout_q <= dout_d;
    end
  end

  // ****************************************************************
  // Configuration memory
  // ****************************************************************
  wire mem_we = in_clear || word_end;
  wire [WORD_WIDTH-1:0] mem_wdata = in_clear ? '0 : word_next;

  config_memory #(
    .WIDTH(WORD_WIDTH),
    .DEPTH(MEM_DEPTH),
    .AW(AW)
  ) u_mem (
    .i_sys_clk(i_sys_clk),
    .i_we(mem_we),
    .i_waddr(addr_q),
    .i_wdata(mem_wdata),
    .i_raddr(i_cfg_raddr),
    .o_rdata(o_cfg_rdata)
  );

  // ****************************************************************
  // Status pins
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hdc_q <= 1'b1;
      ldc_n_q <= 1'b0;
    end else begin
      hdc_q <= io_active ? i_user_hdc : 1'b1; // [R15]
      ldc_n_q <= io_active ? i_user_ldc_n : 1'b0; // [R16]
    end
  end

  assign o_dout = dout_q;
  assign o_init_out = 1'b0;
  assign o_init_oe = in_clear || (state_q == st_no_mode);
  assign o_done_out = 1'b0;
  assign o_done_oe = !done_high; // [R7] [R14]
  assign o_high_during_config = hdc_q;
  assign o_low_during_config_n = ldc_n_q;
  assign o_global_set_reset_net =
    !(state_q inside {st_startup_cycle_three, st_user}); // [R7]
  assign o_user_mode = (state_q == st_user); // [R8]
  assign o_osc_active = (state_q == st_init); // [R5]

endmodule

// ===== design/slave_serial_config_load_map.svh
// Purpose: Constants for the slave serial configuration loader.
// Assumes: A system clock of 25 MHz samples every configuration pin.
// Notes: Timing counts derive from times and the clock rate.
`ifndef SLAVE_SERIAL_CONFIG_LOAD_MAP_SVH
`define SLAVE_SERIAL_CONFIG_LOAD_MAP_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define SSC_SYS_CLK_MHZ 25
`define SSC_INIT_OSC_NS 2000
`define SSC_INIT_OSC_CYC ((`SSC_INIT_OSC_NS * `SSC_SYS_CLK_MHZ + 999) / 1000)

// ****************************************************************
// Bitstream layout
// ****************************************************************
`define SSC_LEN_BITS 24
`define SSC_LEN_RESET 24'h000000

// ****************************************************************
// Synchroniser lane positions
// ****************************************************************
`define SSC_PIN_COUNT 5
`define SSC_PIN_PROG 0
`define SSC_PIN_CLK 1
`define SSC_PIN_DIN 2
`define SSC_PIN_INIT 3
`define SSC_PIN_MODE 4
// The bit clock lane rests low, as the pin does between frames, so no false edge follows reset.
`define SSC_PIN_RESET 5'h1d

`endif

// ===== design/slave_serial_config_load_pkg.sv
// Purpose: Types shared by the slave serial configuration loader.
// Assumes: Nothing beyond the constants header.
// Notes: The state order follows the life of one configuration.
package slave_serial_config_load_pkg;

  typedef enum logic [3:0] {
    st_clear,
    st_init_hold,
    st_init,
    st_no_mode,
    st_load,
    st_wait_cycle_one,
    st_startup_cycle_one,
    st_startup_cycle_two,
    st_startup_cycle_three,
    st_user
  } cfg_state_t;

endpackage

// ===== design/config_memory.sv
// Purpose: Configuration memory with one write port and one registered read port.
// Assumes: Writer and reader share the system clock.
// Notes: Clearing is done by the caller writing zero word by word.
`timescale 1ns/1ps
module config_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_we, // Write strobe.
  input wire logic [AW-1:0] i_waddr, // Write address.
  input wire logic [WIDTH-1:0] i_wdata, // Write data.
  input wire logic [AW-1:0] i_raddr, // Read address.
  output logic [WIDTH-1:0] o_rdata // Registered read data.
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ****************************************************************
  // Storage
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
    o_rdata <= mem_q[i_raddr];
  end

endmodule

// ===== bench/slave_serial_config_load_assertions.sv
// Purpose: Port checks for the slave serial configuration loader.
// Assumes: The bit clock stays at least four system clocks high and low.
// Notes: Bound to every instance of the loader.
`timescale 1ns/1ps
module slave_serial_config_load_assertions (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_nrst, // Reset, active low.
  input wire logic i_program_n, // Program pin.
  input wire logic i_config_bit_clock, // Bit clock pin.
  input wire logic i_user_hdc, // User high-during-config value.
  input wire logic i_user_ldc_n, // User low-during-config value.
  input wire logic o_dout, // Pass-through data.
  input wire logic o_init_oe, // Clear-done pull-down.
  input wire logic o_done_oe, // Done pull-down.
  input wire logic o_high_during_config, // High during configuration.
  input wire logic o_low_during_config_n, // Low during configuration.
  input wire logic o_global_set_reset_net, // Global set/reset.
  input wire logic o_user_mode, // User operation.
  input wire logic o_osc_active // Oscillator running.
);
  // ****************************************************************
  // Clearing, start-up order and status pins
  // ****************************************************************
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_cfg_held;
    o_global_set_reset_net && !o_user_mode;
  endsequence
  sequence s_gsr_gap;
    o_global_set_reset_net [*8];
  endsequence
  a_init_clear: assert property (!i_program_n [*5] |-> o_init_oe)
    else $error("clear-done released while program held low");
  a_dout_fall: assert property ($changed(o_dout) && !o_init_oe |->
    !$past(i_config_bit_clock, 2) && $past(i_config_bit_clock, 5))
    else $error("pass-through changed away from a bit clock fall");
  a_io_after_c1: assert property ($fell(o_done_oe) |-> s_cfg_held ##0 o_high_during_config)
    else $error("done released out of order");
  a_startup_gap: assert property ($fell(o_done_oe) |-> s_gsr_gap)
    else $error("start-up advanced without bit clock edges");
  a_gsr_release: assert property ($fell(o_global_set_reset_net) |-> !o_done_oe && !o_user_mode)
    else $error("global set/reset released out of order");
  a_user_last: assert property ($rose(o_user_mode) |->
    !o_global_set_reset_net && !o_done_oe && !$past(o_global_set_reset_net, 8))
    else $error("user operation began too early");
  a_osc_init: assert property (o_osc_active |-> !o_init_oe ##0 s_cfg_held ##0 o_done_oe)
    else $error("oscillator running outside initialisation");
  a_config_held: assert property (o_done_oe && $past(o_done_oe) && $past(o_done_oe, 2) |->
    o_high_during_config && !o_low_during_config_n)
    else $error("status pins left configuration levels early");
  a_user_values: assert property (o_user_mode && $past(o_user_mode) |->
    o_high_during_config == $past(i_user_hdc) && o_low_during_config_n == $past(i_user_ldc_n))
    else $error("status pins not following user values");
endmodule

bind slave_serial_config_load slave_serial_config_load_assertions u_chk (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_program_n(i_program_n),
  .i_config_bit_clock(i_config_bit_clock), .i_user_hdc(i_user_hdc),
  .i_user_ldc_n(i_user_ldc_n), .o_dout(o_dout), .o_init_oe(o_init_oe), .o_done_oe(o_done_oe),
  .o_high_during_config(o_high_during_config), .o_low_during_config_n(o_low_during_config_n),
  .o_global_set_reset_net(o_global_set_reset_net), .o_user_mode(o_user_mode),
  .o_osc_active(o_osc_active));

// ===== bench/cfg_master.sv
// Purpose: Behavioural controller that clears and clocks a bitstream in.
// Assumes: Bit clock of 320 ns, four system clocks high and four low.
// Notes: The bit clock stands low between frames.
`timescale 1ns/1ps
module cfg_master (
  input wire logic i_sys_clk, // System clock.
  input wire logic i_init_line, // Resolved clear-done line.
  input wire logic i_dout, // Pass-through output of the loader.
  output logic o_program_n, // Program pin.
  output logic o_config_bit_clock, // Bit clock.
  output logic o_din, // Serial data.
  output logic o_mode // Mode pin.
);
  logic bits [0:67];
  logic seen [0:67];
  initial begin
    o_program_n = 1'b1;
    o_config_bit_clock = 1'b0;
    o_din = 1'b0;
    o_mode = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // Waits for clear-done high, then the minimum settling time of 55 us.
  task automatic ready(output bit ok);
    int t;
    ok = 1'b0;
    for (t = 0; t < 3000 && !ok; t++) begin
      tick(1);
      ok = i_init_line;
    end
    tick(1375);
  endtask
  task automatic clear(output bit ok);
    tick(1);
    o_program_n = 1'b0;
    tick(12);
    o_program_n = 1'b1;
    ready(ok);
  endtask
  task automatic send(input int first, input int last);
    for (int i = first; i <= last; i++) begin
      o_din = bits[i];
      tick(4);
      seen[i] = i_dout;
      o_config_bit_clock = 1'b1;
      tick(4);
      o_config_bit_clock = 1'b0;
    end
    o_din = ~o_din;
  endtask
endmodule

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the slave serial configuration loader.
// Assumes: Four words of eight bits, a length count of 64 bits.
// Notes: Random data from a fixed seed; controller in cfg_master.
`timescale 1ns/1ps
module testbench;
  logic clk, nrst, hold, uh, ul;
  logic [1:0] raddr;
  logic prog_n, bclk, din, mode, dout, init_oe, done_oe, high_during_config, ldc_n, global_set_reset_net, user, osc;
  logic init_out, done_out;
  logic [7:0] rdata;
  wire logic init_line = ~init_oe & ~hold;
  int n_fail = 0;
  int n_tests = 0;
  int seed = 32'he4ed163d;
  bit ok;
  logic [31:0] r;
  logic [4:0] stat [0:4] = '{5'h1a, 5'h0a, 5'h06, 5'h04, 5'h05};
  always #20 clk = ~clk;
  cfg_master M (.i_sys_clk(clk), .i_init_line(init_line), .i_dout(dout), .o_program_n(prog_n),
    .o_config_bit_clock(bclk), .o_din(din), .o_mode(mode));
  slave_serial_config_load #(.WORD_WIDTH(8), .MEM_DEPTH(4), .INIT_OSC_CYCLES(4)) DUT (
    .i_sys_clk(clk), .i_nrst(nrst), .i_program_n(prog_n), .i_config_bit_clock(bclk),
    .i_din(din), .i_mode(mode), .i_init_line(init_line), .i_user_hdc(uh), .i_user_ldc_n(ul),
    .i_cfg_raddr(raddr), .o_dout(dout), .o_init_out(init_out), .o_init_oe(init_oe),
    .o_done_out(done_out),
    .o_done_oe(done_oe), .o_high_during_config(high_during_config), .o_low_during_config_n(ldc_n),
    .o_global_set_reset_net(global_set_reset_net), .o_user_mode(user), .o_osc_active(osc), .o_cfg_rdata(rdata));
  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report();
    if (n_fail == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] word(input int a);
    for (int b = 0; b < 8; b++) word[7 - b] = M.bits[24 + 8 * a + b];
  endfunction
  task automatic fill();
    for (int i = 0; i < 68; i++) begin
      r = $random(seed);
      M.bits[i] = (i < 24) ? 1'(24'd64 >> (23 - i)) : r[0];
    end
  endtask
  task automatic bail(input bit good);
    check("bounded wait", good, 1'b1);
    if (!good) final_report();
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    hold = 1'b1;
    uh = 1'b0;
    ul = 1'b1;
    raddr = 2'h0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    check("status after reset", {done_oe, high_during_config, ldc_n, global_set_reset_net, user}, stat[0]);
    check("open-drain values", {init_out, done_out}, 2'b00);
    check("dout after reset", dout, 1'b1);
    M.tick(200);
    check("osc while line held", osc, 1'b0);
    hold = 1'b0;
    ok = 1'b0;
    for (int t = 0; t < 200 && !ok; t++) begin
      M.tick(1);
      ok = osc;
    end
    bail(ok);
    M.ready(ok);
    bail(ok);
    fill();
    M.send(0, 59);
    M.tick(8);
    check("incomplete load", {done_oe, user}, 2'b10);
    M.clear(ok);
    bail(ok);
    fill();
    M.send(0, 30);
    M.tick(300);
    M.send(31, 62);
    for (int s = 0; s < 5; s++) begin
      M.send(63 + s, 63 + s);
      M.tick(2);
      check("start-up step", {done_oe, high_during_config, ldc_n, global_set_reset_net, user}, stat[s]);
    end
    for (int a = 0; a < 4; a++) begin
      raddr = a[1:0];
      M.tick(2);
      check("memory word", rdata, word(a));
    end
    for (int i = 1; i <= 64; i++) begin
      check("pass-through", M.seen[i], (i > 56) ? M.bits[i - 1] : 1'b1);
    end
    for (int i = 0; i < 20; i++) begin
      r = $random(seed);
      uh = r[0];
      ul = r[1];
      M.tick(1);
    end
    M.tick(2);
    check("user hdc value", high_during_config, uh);
    check("user ldc value", ldc_n, ul);
    M.o_mode = 1'b0;
    M.clear(ok);
    bail(ok);
    check("wrong mode refused", {init_oe, user, done_oe}, 3'b101);
    final_report();
  end
endmodule
